// ===== rtl/pis_regs.vh
// Purpose: Register map, field positions, reset values and timing counts
// Assumes: AXI4-Lite, 32-bit data, byte addresses below
// Notes: Included by the shaper top module and the test bench
`ifndef PIS_REGS_VH
`define PIS_REGS_VH

// Clock
`define PIS_CLK_PERIOD_NS 4
`define PIS_NS_PER_US 1000
`define PIS_CYC_PER_US (`PIS_NS_PER_US / `PIS_CLK_PERIOD_NS)

// Register byte offsets
`define PIS_ADDR_W 8
`define PIS_OFF_CTRL 8'h00
`define PIS_OFF_PEAK 8'h04
`define PIS_OFF_FLAT 8'h08
`define PIS_OFF_FAST 8'h0c
`define PIS_OFF_FTHR 8'h10
`define PIS_OFF_PUR 8'h14
`define PIS_OFF_TAU 8'h18
`define PIS_OFF_STAT 8'h1c
`define PIS_OFF_ICLR 8'h20
`define PIS_OFF_IEN 8'h24
`define PIS_OFF_HGT 8'h28
`define PIS_OFF_IVL 8'h2c

// Control fields
`define PIS_CTRL_MSEL 0
`define PIS_CTRL_SHIFT_LO 1
`define PIS_CTRL_SHIFT_HI 5

// Status / interrupt bits
`define PIS_EV_W 3
`define PIS_EV_HEIGHT 0
`define PIS_EV_PILEUP 1
`define PIS_EV_IEND 2

// Reset values (times in 4 ns cycles; PUR in us, TAU in ns)
`define PIS_RST_CTRL 6'h00
`define PIS_RST_PEAK 10'h258
`define PIS_RST_FLAT 10'h0fa
`define PIS_RST_FAST 10'h064
`define PIS_RST_FTHR 32'h00000100
`define PIS_RST_PUR 8'h00
`define PIS_RST_TAU 10'h000

// Longest commanded interval is peaking time shifted by this
`define PIS_PUR_MAX_SHIFT 5

// Bus responses
`define PIS_RESP_OKAY 2'b00
`define PIS_RESP_SLVERR 2'b10

`endif

// ===== rtl/pis_delay_sum.v
// Purpose: Programmable delay line giving a running difference or moving sum
// Assumes: dly below 2**AW; dly of zero acts as one
// Notes: Samples not yet written read as zero after reset
`timescale 1ns/1ps
`default_nettype none
module pis_delay_sum #(
    parameter W = 27,
    parameter AW = 10,
    parameter ACC = 1
) (
    input wire core_clk,
    input wire rst_n,
    input wire signed [W-1:0] din,
    input wire [AW-1:0] dly,
    output wire signed [W+AW-1:0] dout
);
    localparam OW = W + AW;

    reg signed [W-1:0] mem [0:(1<<AW)-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW:0] fill_reg;
    reg signed [OW-1:0] dout_reg;

    wire [AW-1:0] dly_eff = (dly == {AW{1'b0}}) ? {{(AW-1){1'b0}}, 1'b1} : dly;
    wire [AW-1:0] rd_addr = wr_ptr_reg - dly_eff;
    wire signed [W-1:0] old = (fill_reg >= {1'b0, dly_eff}) ? mem[rd_addr] : {W{1'b0}};
    wire signed [OW-1:0] diff = {{AW{din[W-1]}}, din} - {{AW{old[W-1]}}, old};
    wire signed [OW-1:0] dout_next = (ACC != 0) ? dout_reg + diff : diff;

    always @(posedge core_clk) begin
        mem[wr_ptr_reg] <= din;
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            wr_ptr_reg <= {AW{1'b0}};
            fill_reg <= {(AW+1){1'b0}};
            dout_reg <= {OW{1'b0}};
        end else begin
            wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
            if (!fill_reg[AW])
                fill_reg <= fill_reg + {{AW{1'b0}}, 1'b1};
            dout_reg <= dout_next;
        end
    end

    assign dout = dout_reg;
endmodule
`default_nettype wire

// ===== rtl/pis_top.v
// Purpose: Trapezoidal shaper with decay correction and pile-up inspection
// Assumes: ADC samples arrive synchronous to core_clk, one per cycle
// Notes: Registers over AXI4-Lite; times in 4 ns cycles unless noted
//
// What this block does
// - Shapes pulses as trapezoid with programmed peaking rise and flat-top plateau.
// - Without a commanded interval, inspection lasts peaking plus flat-top time.
// - A commanded interval longer than the default replaces the default.
// - Commanded interval is clamped to a maximum set by peaking time.
// - Interval_end_pulse pulse marks the end of every inspection interval.
// - Nonzero time constant corrects a single exponential decay component.
// - Decay correction raises fast-channel amplitude; threshold must be raised.
// - Fast-channel trigger appears on the second monitor output.
// - First monitor output shows shaped or fast signal per selection.
//
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "pis_regs.vh"
module pis_top (
    input wire core_clk,
    input wire rst_n,
    input wire [13:0] adc_data,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    output wire [15:0] monitor_output_a,
    output wire monitor_output_b,
    output wire interval_end_pulse,
    output wire irq
);
    localparam ST_IDLE = 3'b001;
    localparam ST_INSPECT = 3'b010;
    localparam ST_PILED = 3'b100;

    // Configuration and status registers
    reg [5:0] ctrl_reg;
    reg [9:0] peak_reg;
    reg [9:0] flat_reg;
    reg [9:0] fast_reg;
    reg [31:0] fthr_reg;
    reg [7:0] pur_reg;
    reg [9:0] tau_reg;
    reg [`PIS_EV_W-1:0] stat_reg;
    reg [`PIS_EV_W-1:0] ien_reg;
    reg [31:0] hgt_reg;

    // AXI4-Lite slave state
    reg aw_hold_reg;
    reg [7:0] awaddr_reg;
    reg w_hold_reg;
    reg [31:0] wdata_reg;
    reg [3:0] wstrb_reg;
    reg bvalid_reg;
    reg [1:0] bresp_reg;
    reg rvalid_reg;
    reg [31:0] rdata_reg;
    reg [1:0] rresp_reg;

    assign s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
    assign s_axi_wready = ~w_hold_reg & ~bvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = ~rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    wire do_write = aw_hold_reg & w_hold_reg & ~bvalid_reg;
    wire [31:0] wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

    function [31:0] merge;
        input [31:0] old;
        input [31:0] data;
        input [31:0] mask;
        begin
            merge = (old & ~mask) | (data & mask);
        end
    endfunction

    wire wr_ctrl = do_write && awaddr_reg == `PIS_OFF_CTRL;
    wire wr_peak = do_write && awaddr_reg == `PIS_OFF_PEAK;
    wire wr_flat = do_write && awaddr_reg == `PIS_OFF_FLAT;
    wire wr_fast = do_write && awaddr_reg == `PIS_OFF_FAST;
    wire wr_fthr = do_write && awaddr_reg == `PIS_OFF_FTHR;
    wire wr_pur = do_write && awaddr_reg == `PIS_OFF_PUR;
    wire wr_tau = do_write && awaddr_reg == `PIS_OFF_TAU;
    wire wr_iclr = do_write && awaddr_reg == `PIS_OFF_ICLR;
    wire wr_ien = do_write && awaddr_reg == `PIS_OFF_IEN;
    wire wr_ok = wr_ctrl | wr_peak | wr_flat | wr_fast | wr_fthr | wr_pur | wr_tau | wr_iclr | wr_ien;

    wire [31:0] ctrl_m = merge({26'h0000000, ctrl_reg}, wdata_reg, wmask);
    wire [31:0] peak_m = merge({22'h000000, peak_reg}, wdata_reg, wmask);
    wire [31:0] flat_m = merge({22'h000000, flat_reg}, wdata_reg, wmask);
    wire [31:0] fast_m = merge({22'h000000, fast_reg}, wdata_reg, wmask);
    wire [31:0] fthr_m = merge(fthr_reg, wdata_reg, wmask);
    wire [31:0] pur_m = merge({24'h000000, pur_reg}, wdata_reg, wmask);
    wire [31:0] tau_m = merge({22'h000000, tau_reg}, wdata_reg, wmask);
    wire [31:0] ien_m = merge({29'h00000000, ien_reg}, wdata_reg, wmask);
    wire [`PIS_EV_W-1:0] clr_bits = wr_iclr ? (wdata_reg[`PIS_EV_W-1:0] & wmask[`PIS_EV_W-1:0]) : 3'h0;
    // Interval in use, read back by software
    reg [15:0] ivl_reg;
    reg [31:0] rd_mux;
    reg rd_ok;
    always @* begin
        rd_ok = 1'b1;
        case (s_axi_araddr)
            `PIS_OFF_CTRL: rd_mux = {26'h0000000, ctrl_reg};
            `PIS_OFF_PEAK: rd_mux = {22'h000000, peak_reg};
            `PIS_OFF_FLAT: rd_mux = {22'h000000, flat_reg};
            `PIS_OFF_FAST: rd_mux = {22'h000000, fast_reg};
            `PIS_OFF_FTHR: rd_mux = fthr_reg;
            `PIS_OFF_PUR: rd_mux = {24'h000000, pur_reg};
            `PIS_OFF_TAU: rd_mux = {22'h000000, tau_reg};
            `PIS_OFF_STAT: rd_mux = {29'h00000000, stat_reg};
            `PIS_OFF_ICLR: rd_mux = 32'h00000000;
            `PIS_OFF_IEN: rd_mux = {29'h00000000, ien_reg};
            `PIS_OFF_HGT: rd_mux = hgt_reg;
            `PIS_OFF_IVL: rd_mux = {16'h0000, ivl_reg};
            default: begin
                rd_mux = 32'h00000000;
                rd_ok = 1'b0;
            end
        endcase
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            aw_hold_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            w_hold_reg <= 1'b0;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `PIS_RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= `PIS_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_ok ? `PIS_RESP_OKAY : `PIS_RESP_SLVERR;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_mux;
                rresp_reg <= rd_ok ? `PIS_RESP_OKAY : `PIS_RESP_SLVERR;
            end else if (rvalid_reg && s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // Decay correction: y = x + tau * dx / T, one exponential only
    reg [13:0] adc_reg;
    reg [13:0] adc_prev_reg;
    reg signed [26:0] corr_reg;
    wire signed [14:0] adc_diff = $signed({1'b0, adc_reg}) - $signed({1'b0, adc_prev_reg});
    wire signed [25:0] tau_prod = adc_diff * $signed({1'b0, tau_reg});
    wire signed [31:0] tau_quot = tau_prod / `PIS_CLK_PERIOD_NS;
    wire signed [25:0] tau_term = tau_quot[25:0];
    wire signed [26:0] corr_next = (tau_reg != 10'h000) ?
        $signed({13'h0000, adc_reg}) + {tau_term[25], tau_term} : $signed({13'h0000, adc_reg});

    always @(posedge core_clk) begin
        if (!rst_n) begin
            adc_reg <= 14'h0000;
            adc_prev_reg <= 14'h0000;
            corr_reg <= 27'h0000000;
        end else begin
            adc_reg <= adc_data;
            adc_prev_reg <= adc_reg;
            corr_reg <= corr_next;
        end
    end

    // Slow channel: moving sum over peaking time, then difference over peak plus flat
    wire signed [36:0] slow_sum;
    wire signed [47:0] trap;
    wire [10:0] trap_dly = {1'b0, peak_reg} + {1'b0, flat_reg};
    pis_delay_sum #(.W(27), .AW(10), .ACC(1)) u_slow_sum (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .din(corr_reg),
        .dly(peak_reg),
        .dout(slow_sum)
    );
    pis_delay_sum #(.W(37), .AW(11), .ACC(0)) u_trap (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .din(slow_sum),
        .dly(trap_dly),
        .dout(trap)
    );

    // Fast channel: triangle from the corrected signal, so its gain rises with correction
    wire signed [36:0] fast_sum;
    wire signed [46:0] fast_tri;
    pis_delay_sum #(.W(27), .AW(10), .ACC(1)) u_fast_sum (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .din(corr_reg),
        .dly(fast_reg),
        .dout(fast_sum)
    );
    pis_delay_sum #(.W(37), .AW(10), .ACC(0)) u_fast_tri (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .din(fast_sum),
        .dly(fast_reg),
        .dout(fast_tri)
    );
    reg above_reg;
    wire above = fast_tri > $signed({{15{fthr_reg[31]}}, fthr_reg});
    wire trig = above & ~above_reg;

    // Inspection interval selection
    wire [15:0] dflt_cyc = {5'h00, trap_dly};
    wire [31:0] cmd_prod = pur_reg * `PIS_CYC_PER_US;
    wire [15:0] cmd_cyc = cmd_prod[15:0];
    wire [15:0] max_cyc = {1'b0, peak_reg, 5'h00};
    wire [15:0] cmd_lim = (cmd_cyc > max_cyc) ? max_cyc : cmd_cyc;
    wire [15:0] ivl_next = (cmd_lim > dflt_cyc) ? cmd_lim : dflt_cyc;

    reg [2:0] state_reg;
    reg [15:0] cnt_reg;
    reg [47:0] max_reg;
    reg iend_reg;
    reg [`PIS_EV_W-1:0] ev;
    wire [15:0] ivl_load = (ivl_reg == 16'h0000) ? 16'h0000 : ivl_reg - 16'h0001;

    always @(posedge core_clk) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 16'h0000;
            max_reg <= 48'h000000000000;
            hgt_reg <= 32'h00000000;
            iend_reg <= 1'b0;
            ev <= 3'h0;
            above_reg <= 1'b0;
            ivl_reg <= 16'h0000;
        end else begin
            above_reg <= above;
            ivl_reg <= ivl_next;
            iend_reg <= 1'b0;
            ev <= 3'h0;
            case (state_reg)
                ST_IDLE: begin
                    if (trig) begin
                        state_reg <= ST_INSPECT;
                        cnt_reg <= ivl_load;
                        max_reg <= 48'h000000000000;
                    end
                end
                ST_INSPECT, ST_PILED: begin
                    if (trig) begin
                        state_reg <= ST_PILED;
                        cnt_reg <= ivl_load;
                    end else if (cnt_reg == 16'h0000) begin
                        iend_reg <= 1'b1;
                        ev[`PIS_EV_IEND] <= 1'b1;
                        state_reg <= ST_IDLE;
                        if (state_reg == ST_INSPECT) begin
                            hgt_reg <= max_reg[31:0];
                            ev[`PIS_EV_HEIGHT] <= 1'b1;
                        end else begin
                            ev[`PIS_EV_PILEUP] <= 1'b1;
                        end
                    end else begin
                        cnt_reg <= cnt_reg - 16'h0001;
                        if (trap > $signed(max_reg))
                            max_reg <= trap;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Configuration writes and sticky status; a new event wins over a clear
    always @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl_reg <= `PIS_RST_CTRL;
            peak_reg <= `PIS_RST_PEAK;
            flat_reg <= `PIS_RST_FLAT;
            fast_reg <= `PIS_RST_FAST;
            fthr_reg <= `PIS_RST_FTHR;
            pur_reg <= `PIS_RST_PUR;
            tau_reg <= `PIS_RST_TAU;
            ien_reg <= 3'h0;
            stat_reg <= 3'h0;
        end else begin
            if (wr_ctrl) ctrl_reg <= ctrl_m[5:0];
            if (wr_peak) peak_reg <= peak_m[9:0];
            if (wr_flat) flat_reg <= flat_m[9:0];
            if (wr_fast) fast_reg <= fast_m[9:0];
            if (wr_fthr) fthr_reg <= fthr_m;
            if (wr_pur) pur_reg <= pur_m[7:0];
            if (wr_tau) tau_reg <= tau_m[9:0];
            if (wr_ien) ien_reg <= ien_m[2:0];
            stat_reg <= (stat_reg & ~clr_bits) | ev;
        end
    end

    // Monitor outputs
    reg [15:0] mon_a_reg;
    reg mon_b_reg;
    wire [4:0] gain_sh = ctrl_reg[`PIS_CTRL_SHIFT_HI:`PIS_CTRL_SHIFT_LO];
    wire signed [47:0] trap_sh = trap >>> gain_sh;
    wire signed [46:0] fast_sh = fast_tri >>> gain_sh;

    always @(posedge core_clk) begin
        if (!rst_n) begin
            mon_a_reg <= 16'h0000;
            mon_b_reg <= 1'b0;
        end else begin
            mon_a_reg <= ctrl_reg[`PIS_CTRL_MSEL] ? fast_sh[15:0] : trap_sh[15:0];
            mon_b_reg <= trig;
        end
    end

    assign monitor_output_a = mon_a_reg;
    assign monitor_output_b = mon_b_reg;
    assign interval_end_pulse = iend_reg;
    assign irq = |(stat_reg & ien_reg);
endmodule
`default_nettype wire

// ===== tb/pis_adc_src.sv
// Purpose: Charge amplifier output as seen through the ADC
// Assumes: Single exponential light decay of 57.5 cycles
// Notes: Slow droop of the amplifier keeps the baseline from drifting
`timescale 1ns/1ps
`default_nettype none
module pis_adc_src (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic fire,
    input wire logic [13:0] amp,
    output logic [13:0] adc_data
);
    real rem;
    real q;
    real dq;
    always @(posedge core_clk) begin
        if (!rst_n) begin
            rem = 0.0;
            q = 0.0;
        end else begin
            if (fire)
                rem = rem + amp;
            dq = rem / 57.5;
            rem = rem - dq;
            q = q + dq - q / 4000.0;
        end
        adc_data <= 14'($rtoi(q) + 500);
    end
endmodule
`default_nettype wire

// ===== tb/pis_top_assertions.sv
// Purpose: Port-level checks of the shaper and its register bus
// Assumes: Single clock domain, synchronous active-low reset
// Notes: Bound onto every pis_top instance
`timescale 1ns/1ps
`default_nettype none
module pis_top_chk (
    input wire core_clk,
    input wire rst_n,
    input wire [13:0] adc_data,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [15:0] monitor_output_a,
    input wire monitor_output_b,
    input wire interval_end_pulse,
    input wire irq
);
    reg busy_reg;
    always @(posedge core_clk) begin
        if (!rst_n)
            busy_reg <= 1'b0;
        else if (monitor_output_b)
            busy_reg <= 1'b1;
        else if (interval_end_pulse)
            busy_reg <= 1'b0;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    AST_IEP_ONE: assert property (interval_end_pulse |=> !interval_end_pulse)
        else $error("interval end pulse wider than one cycle");
    AST_TRIG_ONE: assert property (monitor_output_b |=> !monitor_output_b)
        else $error("trigger pulse wider than one cycle");
    AST_IEP_CAUSE: assert property (interval_end_pulse |-> busy_reg)
        else $error("interval end without a trigger");
    AST_WR_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    AST_BBLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    AST_ARRDY: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    AST_B_ONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    AST_R_ONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
    AST_RD_UNMAP: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0)
        else $error("error read returned data");
    cover property (interval_end_pulse ##1 irq);
    cover property (monitor_output_b && busy_reg);
    cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule
bind pis_top pis_top_chk u_chk (.core_clk(core_clk), .rst_n(rst_n), .adc_data(adc_data),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .monitor_output_a(monitor_output_a),
    .monitor_output_b(monitor_output_b), .interval_end_pulse(interval_end_pulse), .irq(irq));
`default_nettype wire

// ===== tb/pis_top_test.sv
// Purpose: Self-checking bench for the shaper and pile-up inspection
// Assumes: Pulses well separated unless pile-up is wanted
// Notes: Tail settling waits are generous to avoid retriggers
`timescale 1ns/1ps
`default_nettype none
`include "pis_regs.vh"
module pis_top_test;
    logic core_clk, rst_n, fire, clr, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [13:0] amp;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] r;
    wire [13:0] adc_data;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire monitor_output_b, interval_end_pulse, irq;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [15:0] monitor_output_a;
    integer n_mismatch, check_count, seed, pk, wid, cnt, gap, i, a, p, f, u, pk0;
    localparam [383:0] RT = {32'h352, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h100, 32'h64, 32'hfa,
        32'h258, 32'h0};
    pis_top dut (.core_clk(core_clk), .rst_n(rst_n), .adc_data(adc_data), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .monitor_output_a(monitor_output_a), .monitor_output_b(monitor_output_b),
        .interval_end_pulse(interval_end_pulse), .irq(irq));
    pis_adc_src src (.core_clk(core_clk), .rst_n(rst_n), .fire(fire), .amp(amp), .adc_data(adc_data));
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        repeat (90000) @(posedge core_clk);
        n_mismatch = n_mismatch + 1;
        stop_test;
    end
    // Cycles since trigger, peak and width of the monitor trace
    always @(posedge core_clk) begin
        cnt <= monitor_output_b ? 0 : cnt + 1;
        if (interval_end_pulse)
            gap <= cnt;
        if (clr) begin
            pk <= -100000;
            wid <= 0;
        end else begin
            if ($signed(monitor_output_a) > pk)
                pk <= $signed(monitor_output_a);
            if ($signed(monitor_output_a) > 0)
                wid <= wid + 1;
        end
    end
    function automatic integer ivl_exp(input integer pp, input integer ff, input integer uu);
        integer c;
        begin
            c = (uu * 250 < pp * 32) ? uu * 250 : pp * 32;
            ivl_exp = (c > pp + ff) ? c : pp + ff;
        end
    endfunction
    task automatic chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            check_count = check_count + 1;
            if (g !== e) begin
                n_mismatch = n_mismatch + 1;
                $display("[ERR] %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task automatic wr(input [7:0] ad, input [31:0] dt, output [1:0] rs);
        begin
            @(posedge core_clk);
            s_axi_awaddr <= ad;
            s_axi_wdata <= dt;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            forever begin
                @(posedge core_clk);
                if (s_axi_awvalid && s_axi_awready)
                    s_axi_awvalid <= 1'b0;
                if (s_axi_wvalid && s_axi_wready)
                    s_axi_wvalid <= 1'b0;
                if (s_axi_bvalid === 1'b1 && s_axi_bready) begin
                    rs = s_axi_bresp;
                    s_axi_bready <= 1'b0;
                    break;
                end
            end
        end
    endtask
    task automatic rd(input [7:0] ad, output [31:0] dt, output [1:0] rs);
        begin
            @(posedge core_clk);
            s_axi_araddr <= ad;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            forever begin
                @(posedge core_clk);
                if (s_axi_arvalid && s_axi_arready)
                    s_axi_arvalid <= 1'b0;
                if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
                    dt = s_axi_rdata;
                    rs = s_axi_rresp;
                    s_axi_rready <= 1'b0;
                    break;
                end
            end
        end
    endtask
    task automatic pulse(input integer sep, input [2:0] st, input logic iq);
        integer n;
        begin
            @(posedge core_clk);
            clr <= 1'b1;
            fire <= 1'b1;
            amp <= a[13:0];
            @(posedge core_clk);
            clr <= 1'b0;
            fire <= 1'b0;
            if (sep > 0) begin
                repeat (sep) @(posedge core_clk);
                fire <= 1'b1;
                @(posedge core_clk);
                fire <= 1'b0;
            end
            n = 0;
            while (interval_end_pulse !== 1'b1 && n < 40000) begin
                @(posedge core_clk);
                n = n + 1;
            end
            repeat (6000) @(posedge core_clk);
            rd(`PIS_OFF_STAT, d, r);
            chk("status", {29'h0, st}, d);
            chk("irq", {31'h0, iq}, {31'h0, irq});
            wr(`PIS_OFF_ICLR, 32'h7, r);
            rd(`PIS_OFF_STAT, d, r);
            chk("cleared", 32'h0, d);
            chk("irq_off", 32'h0, {31'h0, irq});
        end
    endtask
    task automatic stop_test;
        begin
            if (n_mismatch == 0 && check_count > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    initial begin
        {fire, clr, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h0;
        {amp, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 62'h0;
        s_axi_wstrb = 4'hf;
        rst_n = 1'b0;
        {n_mismatch, check_count} = 64'h0;
        seed = 32'habac;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        for (i = 0; i < 12; i = i + 1) begin
            rd(8'(i * 4), d, r);
            chk("reset_value", RT[i*32 +: 32], d);
        end
        wr(`PIS_OFF_STAT, 32'hffffffff, r);
        rd(`PIS_OFF_STAT, d, r);
        chk("read_only", 32'h0, d);
        wr(8'h30, 32'h1, r);
        chk("unmapped_bresp", {30'h0, `PIS_RESP_SLVERR}, {30'h0, r});
        rd(8'h30, d, r);
        chk("unmapped_rresp", {30'h0, `PIS_RESP_SLVERR}, {30'h0, r});
        chk("unmapped_rdata", 32'h0, d);
        for (i = 0; i < 16; i = i + 1) begin
            p = ($random(seed) & 1023) | 1;
            f = $random(seed) & 1023;
            u = $random(seed) & 255;
            if (i == 0) begin p = 1023; f = 1023; u = 255; end
            if (i == 1) begin p = 1; f = 1; u = 1; end
            if (i == 2) begin p = 600; f = 250; u = 3; end
            wr(`PIS_OFF_PEAK, p, r);
            wr(`PIS_OFF_FLAT, f, r);
            wr(`PIS_OFF_PUR, u, r);
            chk("bresp", {30'h0, `PIS_RESP_OKAY}, {30'h0, r});
            rd(`PIS_OFF_IVL, d, r);
            chk("interval", ivl_exp(p, f, u), d);
        end
        repeat (3000) @(posedge core_clk);
        wr(`PIS_OFF_ICLR, 32'h7, r);
        wr(`PIS_OFF_PEAK, 32'd600, r);
        wr(`PIS_OFF_FLAT, 32'd250, r);
        wr(`PIS_OFF_PUR, 32'd8, r);
        wr(`PIS_OFF_IEN, 32'h7, r);
        a = 1500 + ($random(seed) & 1023);
        pulse(0, 3'b101, 1'b1);
        chk("interval_len", 32'h1, gap >= 1997 && gap <= 2002);
        pulse(400, 3'b110, 1'b1);
        chk("restart_len", 32'h1, gap >= 1997 && gap <= 2002);
        wr(`PIS_OFF_IEN, 32'h0, r);
        pulse(0, 3'b101, 1'b0);
        wr(`PIS_OFF_CTRL, 32'hd, r);
        pulse(0, 3'b101, 1'b0);
        pk0 = pk;
        chk("fast_width", 32'h1, wid < 600);
        wr(`PIS_OFF_TAU, 32'd230, r);
        pulse(0, 3'b101, 1'b0);
        chk("fast_gain", 32'h1, pk > pk0);
        wr(`PIS_OFF_CTRL, 32'h14, r);
        pulse(0, 3'b101, 1'b0);
        chk("shaped_width", 32'h1, wid > 600);
        stop_test;
    end
endmodule
`default_nettype wire
